// ===== bcc_cfg.svh
// Register map, field positions, reset values and timing counts of the converter register bank
`ifndef BCC_CFG_SVH
`define BCC_CFG_SVH

// Register addresses on the serial port
`define BCC_ADDR_SETPOINT 8'h00
`define BCC_ADDR_MAIN 8'h01
`define BCC_ADDR_RANGE 8'h02
`define BCC_ADDR_AUX 8'h03
`define BCC_ADDR_FLAGS 8'h04

// Seven-bit target address of the serial port
`define BCC_TARGET_ADDR 7'h4a

// Main control field positions and reset (bit 7 is never stored)
`define BCC_MAIN_SWRST_BIT 7
`define BCC_MAIN_SSC_BIT 6
`define BCC_MAIN_SW_BIT 5
`define BCC_MAIN_FPWM_BIT 4
`define BCC_MAIN_DISCH_BIT 3
`define BCC_MAIN_RETRY_BIT 2
`define BCC_MAIN_RESET 7'h2a

// Range and soft-start fields
`define BCC_SCALE_HI 3
`define BCC_SCALE_LO 2
`define BCC_SS_RESET 2'h1
`define BCC_SCALE_TOP 2'h3

// Auxiliary control and event flag resets
`define BCC_AUX_RESET 8'h00
`define BCC_FLAGS_RESET 6'h02

// Setpoint arithmetic in microvolts: 400000, 800000, 1250, 2500, 5000, 10000
`define BCC_BASE_LOW_UV 22'h061a80
`define BCC_BASE_HIGH_UV 22'h0c3500
`define BCC_STEP_R1_UV 22'h0004e2
`define BCC_STEP_R2_UV 22'h0009c4
`define BCC_STEP_R3_UV 22'h001388
`define BCC_STEP_R4_UV 22'h002710

// Slew in uV/us: 10000, 5000, 1250, 500
`define BCC_SLEW_0 14'h2710
`define BCC_SLEW_1 14'h1388
`define BCC_SLEW_2 14'h04e2
`define BCC_SLEW_3 14'h01f4

// Soft-start duration in us: 500, 1000, 2000, 4000
`define BCC_SS_0 13'h01f4
`define BCC_SS_1 13'h03e8
`define BCC_SS_2 13'h07d0
`define BCC_SS_3 13'h0fa0

// Serial byte framing and strap capture delay
`define BCC_BITS_PER_BYTE 4'h8
`define BCC_STRAP_WAIT 2'h2

// Mode pin activity window: a least time, rounded up to cycles
`define BCC_CLK_NS 10
`define BCC_MODE_HOLD_NS 2000
`define BCC_MODE_HOLD_CYC 8'((`BCC_MODE_HOLD_NS + `BCC_CLK_NS - 1) / `BCC_CLK_NS)

`endif

// ===== bcc_pkg.sv
// Types shared by the converter register bank
package bcc_pkg;
    typedef enum logic [3:0] {
        st_idle = 4'h0,
        st_devaddr = 4'h1,
        st_ack_addr = 4'h2,
        st_regaddr = 4'h3,
        st_ack_reg = 4'h4,
        st_wdata = 4'h5,
        st_ack_w = 4'h6,
        st_rdata = 4'h7,
        st_ack_r = 4'h8
    } bcc_state_t;
endpackage

// ===== bcc_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module bcc_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // bcc_sync

// ===== bcc_regbank.sv
// Converter configuration and status register bank behind a two-wire serial target port
`timescale 1ns/1ps
`include "bcc_cfg.svh"
module bcc_regbank (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [7:0] setpoint_strap_pins,
    input wire logic [1:0] setpoint_strap_scale,
    input wire logic mode_sync_pin,
    input wire logic [5:0] event_in,
    output logic [7:0] output_setpoint_code,
    output logic [1:0] setpoint_scale_select,
    output logic [21:0] target_uv,
    output logic spread_spectrum_on,
    output logic switching_on,
    output logic forced_fixed_freq_on,
    output logic output_discharge_on,
    output logic retry_mode_on,
    output logic [1:0] setpoint_slew_select,
    output logic [13:0] slew_uv_per_us,
    output logic [1:0] softstart_duration,
    output logic [12:0] softstart_us,
    output logic [7:0] auxiliary_control,
    output logic init_start
);
    logic [18:0] raw_in;
    logic [18:0] sync_out;
    logic scl_s, sda_s, mode_s;
    logic [5:0] ev_s;
    logic [7:0] strap_code_s;
    logic [1:0] strap_scale_s;
    logic scl_q, sda_q, mode_q;
    logic [7:0] mode_cnt;
    logic [7:0] strap_code_q;
    logic [1:0] strap_scale_q;
    logic strap_done;
    logic [1:0] cap_cnt;
    bcc_pkg::bcc_state_t state;
    logic [7:0] shreg, tx, ptr;
    logic [3:0] bitcnt;
    logic rw, nack;
    logic [6:0] main_ctl;
    logic [5:0] flags;
    logic [7:0] rd_data;

    // All pin-side inputs cross into sys_clk before anything reads them
    assign raw_in = {scl_in, sda_in, mode_sync_pin, event_in, setpoint_strap_pins,
                     setpoint_strap_scale};
    bcc_sync #(.W(19)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(raw_in),
        .q(sync_out)
    );
    assign scl_s = sync_out[18];
    assign sda_s = sync_out[17];
    assign mode_s = sync_out[16];
    assign ev_s = sync_out[15:10];
    assign strap_code_s = sync_out[9:2];
    assign strap_scale_s = sync_out[1:0];

    // Bus condition decode from sampled pin levels
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire start_det = scl_s && scl_q && sda_q && !sda_s;
    wire stop_det = scl_s && scl_q && !sda_q && sda_s;
    wire tx_load = scl_fall && !start_det && !stop_det
                   && ((state == bcc_pkg::st_ack_addr && rw)
                   || (state == bcc_pkg::st_ack_r && !nack));
    wire counting = (state == bcc_pkg::st_devaddr) || (state == bcc_pkg::st_regaddr)
                    || (state == bcc_pkg::st_wdata) || (state == bcc_pkg::st_rdata);

    // Register side events
    wire cap = !strap_done && (cap_cnt == `BCC_STRAP_WAIT);
    wire wr_en = strap_done && (state == bcc_pkg::st_ack_w) && scl_fall;
    wire swrst = wr_en && (ptr == `BCC_ADDR_MAIN) && shreg[`BCC_MAIN_SWRST_BIT];
    // Flags clear in the cycle they are loaded for sending, so no event slips by unreported
    wire status_clr = strap_done && tx_load && (ptr == `BCC_ADDR_FLAGS);
    wire [7:0] strap_code_use = cap ? strap_code_s : strap_code_q;
    wire [1:0] strap_scale_use = cap ? strap_scale_s : strap_scale_q;

    // Read decode; unmapped addresses read zero and the soft reset bit reads zero
    function automatic logic [7:0] read_reg(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        unique case (a)
            `BCC_ADDR_SETPOINT: r = output_setpoint_code;
            `BCC_ADDR_MAIN: r = {1'b0, main_ctl};
            `BCC_ADDR_RANGE: r = {4'h0, setpoint_scale_select, softstart_duration};
            `BCC_ADDR_AUX: r = auxiliary_control;
            `BCC_ADDR_FLAGS: r = {2'b00, flags};
            default: r = 8'h00;
        endcase
        return r;
    endfunction
    always_comb begin
        rd_data = read_reg(ptr); // A process also wakes on registers read inside the function
    end

    // Setpoint target in microvolts from code and scale
    function automatic logic [21:0] calc_target(input logic [7:0] code, input logic [1:0] sc);
        logic [21:0] step;
        logic [21:0] base;
        step = `BCC_STEP_R1_UV;
        base = `BCC_BASE_LOW_UV;
        unique case (sc)
            2'h0: step = `BCC_STEP_R1_UV;
            2'h1: step = `BCC_STEP_R2_UV;
            2'h2: step = `BCC_STEP_R3_UV;
            2'h3: begin
                step = `BCC_STEP_R4_UV;
                base = `BCC_BASE_HIGH_UV;
            end
        endcase
        return 22'(base + 22'(code) * step);
    endfunction

    // Strap capture once after power-on reset; soft reset reuses the stored copy
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt <= 2'h0;
            strap_done <= 1'b0;
            strap_code_q <= 8'h00;
            strap_scale_q <= 2'h0;
        end else if (cap) begin
            strap_done <= 1'b1;
            strap_code_q <= strap_code_s;
            strap_scale_q <= strap_scale_s;
        end else if (!strap_done) begin
            cap_cnt <= cap_cnt + 2'h1;
        end
    end

    // Previous pin samples for edge detection
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 1'b0;
            sda_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            mode_q <= mode_s;
        end
    end

    // Serial target engine; ignores the bus until straps are captured
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= bcc_pkg::st_idle;
            shreg <= 8'h00;
            tx <= 8'h00;
            ptr <= 8'h00;
            bitcnt <= 4'h0;
            rw <= 1'b0;
            nack <= 1'b0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else if (!strap_done || stop_det) begin
            state <= bcc_pkg::st_idle;
            sda_oe <= 1'b0;
        end else if (start_det) begin
            state <= bcc_pkg::st_devaddr;
            bitcnt <= 4'h0;
            sda_oe <= 1'b0;
        end else begin
            if (scl_rise && counting) begin
                shreg <= {shreg[6:0], sda_s};
                bitcnt <= bitcnt + 4'h1;
            end
            if (scl_rise && state == bcc_pkg::st_ack_r) begin
                nack <= sda_s;
            end
            if (scl_fall) begin
                unique case (state)
                    bcc_pkg::st_idle: begin
                    end
                    bcc_pkg::st_devaddr: begin
                        if (bitcnt == `BCC_BITS_PER_BYTE) begin
                            if (shreg[7:1] == `BCC_TARGET_ADDR) begin
                                state <= bcc_pkg::st_ack_addr;
                                rw <= shreg[0];
                                sda_oe <= 1'b1;
                            end else begin
                                state <= bcc_pkg::st_idle;
                            end
                        end
                    end
                    bcc_pkg::st_ack_addr: begin
                        bitcnt <= 4'h0;
                        if (rw) begin
                            tx <= rd_data;
                            sda_oe <= ~rd_data[7];
                            state <= bcc_pkg::st_rdata;
                        end else begin
                            sda_oe <= 1'b0;
                            state <= bcc_pkg::st_regaddr;
                        end
                    end
                    bcc_pkg::st_regaddr: begin
                        if (bitcnt == `BCC_BITS_PER_BYTE) begin
                            ptr <= shreg;
                            sda_oe <= 1'b1;
                            state <= bcc_pkg::st_ack_reg;
                        end
                    end
                    bcc_pkg::st_ack_reg, bcc_pkg::st_ack_w: begin
                        // Pointer steps after each committed byte for burst writes
                        if (state == bcc_pkg::st_ack_w) begin
                            ptr <= ptr + 8'h01;
                        end
                        sda_oe <= 1'b0;
                        bitcnt <= 4'h0;
                        state <= bcc_pkg::st_wdata;
                    end
                    bcc_pkg::st_wdata: begin
                        if (bitcnt == `BCC_BITS_PER_BYTE) begin
                            sda_oe <= 1'b1;
                            state <= bcc_pkg::st_ack_w;
                        end
                    end
                    bcc_pkg::st_rdata: begin
                        if (bitcnt == `BCC_BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            ptr <= ptr + 8'h01;
                            state <= bcc_pkg::st_ack_r;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            sda_oe <= ~tx[6];
                        end
                    end
                    bcc_pkg::st_ack_r: begin
                        if (!nack) begin
                            tx <= rd_data;
                            sda_oe <= ~rd_data[7];
                            bitcnt <= 4'h0;
                            state <= bcc_pkg::st_rdata;
                        end else begin
                            state <= bcc_pkg::st_idle;
                        end
                    end
                    default: state <= bcc_pkg::st_idle;
                endcase
            end
        end
    end

    // Configuration registers; the soft reset bit itself is never stored
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_setpoint_code <= 8'h00;
            setpoint_scale_select <= 2'h0;
            main_ctl <= `BCC_MAIN_RESET;
            softstart_duration <= `BCC_SS_RESET;
            auxiliary_control <= `BCC_AUX_RESET;
        end else if (cap || swrst) begin
            output_setpoint_code <= strap_code_use;
            setpoint_scale_select <= strap_scale_use;
            main_ctl <= `BCC_MAIN_RESET;
            softstart_duration <= `BCC_SS_RESET;
            auxiliary_control <= `BCC_AUX_RESET;
        end else if (wr_en) begin
            unique case (ptr)
                `BCC_ADDR_SETPOINT: output_setpoint_code <= shreg;
                `BCC_ADDR_MAIN: main_ctl <= shreg[6:0];
                `BCC_ADDR_RANGE: begin
                    setpoint_scale_select <= shreg[`BCC_SCALE_HI:`BCC_SCALE_LO];
                    softstart_duration <= shreg[1:0];
                end
                `BCC_ADDR_AUX: auxiliary_control <= shreg;
                default: begin
                end
            endcase
        end
    end

    // Event flags: an event in the clearing cycle survives the clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags <= `BCC_FLAGS_RESET;
        end else if (swrst) begin
            flags <= `BCC_FLAGS_RESET;
        end else begin
            flags <= (flags & ~{6{status_clr}}) | ev_s;
        end
    end

    // A clocked mode pin counts as high while edges keep arriving within the window
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_cnt <= 8'h00;
        end else if (mode_s != mode_q) begin
            mode_cnt <= `BCC_MODE_HOLD_CYC;
        end else if (mode_cnt != 8'h00) begin
            mode_cnt <= mode_cnt - 8'h01;
        end
    end

    // Control fields straight from register bits
    assign spread_spectrum_on = main_ctl[`BCC_MAIN_SSC_BIT];
    assign switching_on = main_ctl[`BCC_MAIN_SW_BIT];
    assign output_discharge_on = main_ctl[`BCC_MAIN_DISCH_BIT];
    assign retry_mode_on = main_ctl[`BCC_MAIN_RETRY_BIT];
    assign setpoint_slew_select = main_ctl[1:0];

    // Registered decodes so that every output leaves a flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_uv <= 22'h000000;
            slew_uv_per_us <= `BCC_SLEW_2;
            softstart_us <= `BCC_SS_1;
            forced_fixed_freq_on <= 1'b0;
            init_start <= 1'b0;
        end else begin
            target_uv <= calc_target(output_setpoint_code, setpoint_scale_select);
            slew_uv_per_us <= (main_ctl[1:0] == 2'h0) ? `BCC_SLEW_0 :
                              (main_ctl[1:0] == 2'h1) ? `BCC_SLEW_1 :
                              (main_ctl[1:0] == 2'h2) ? `BCC_SLEW_2 : `BCC_SLEW_3;
            softstart_us <= (softstart_duration == 2'h0) ? `BCC_SS_0 :
                            (softstart_duration == 2'h1) ? `BCC_SS_1 :
                            (softstart_duration == 2'h2) ? `BCC_SS_2 : `BCC_SS_3;
            forced_fixed_freq_on <= main_ctl[`BCC_MAIN_FPWM_BIT] | mode_s
                                    | (mode_cnt != 8'h00);
            init_start <= swrst || cap;
        end
    end

    // Checks
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_wr_commit_edge: assert property ($changed(output_setpoint_code) |->
        $past(cap || swrst || (wr_en && ptr == `BCC_ADDR_SETPOINT)))
        else $error("setpoint changed without a commit");
    a_swrst_defaults: assert property (swrst |=> main_ctl == `BCC_MAIN_RESET
        && output_setpoint_code == strap_code_q && auxiliary_control == `BCC_AUX_RESET)
        else $error("soft reset did not restore defaults");
    a_init_pulse_once: assert property (swrst |=> init_start ##1 !init_start)
        else $error("init pulse wrong");
    a_status_clear_read: assert property (status_clr |=> flags == $past(ev_s))
        else $error("status not cleared by read");
    a_flags_sticky: assert property (!status_clr && !swrst |=>
        (flags & $past(flags)) == $past(flags))
        else $error("flag lost without read");
    a_range_write_nibble: assert property (wr_en && ptr == `BCC_ADDR_RANGE && !swrst |=>
        {setpoint_scale_select, softstart_duration} == $past(shreg[3:0]))
        else $error("range register write wrong");
    a_target_high_range: assert property (setpoint_scale_select == `BCC_SCALE_TOP |=>
        target_uv == 22'(`BCC_BASE_HIGH_UV + 22'($past(output_setpoint_code))
        * `BCC_STEP_R4_UV))
        else $error("range 4 target wrong");
    a_forced_mode_or: assert property (mode_s || main_ctl[`BCC_MAIN_FPWM_BIT] |=>
        forced_fixed_freq_on)
        else $error("forced mode not asserted");
    a_unmapped_read_zero: assert property (state == bcc_pkg::st_ack_addr && scl_fall && rw
        && !start_det && !stop_det && ptr > `BCC_ADDR_FLAGS |=> tx == 8'h00)
        else $error("unmapped read not zero");
endmodule // bcc_regbank

// ===== bcc_ctl_model.sv
// Serial bus controller model that reaches the converter register bank
`timescale 1ns/1ps
`include "bcc_cfg.svh"
module bcc_ctl_model (
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    localparam realtime Q = 31.25; // Quarter of the 125 ns serial clock period
    logic sda_drv;
    logic [2:0] acks;
    // Open-drain data line with pull-up: low whenever either party pulls it
    assign sda = sda_drv & ~sda_oe;
    // Clock stands high between frames, data released
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        acks = 3'h7;
    end
    // Start or repeated start: data falls while the clock is high
    task automatic start();
        sda_drv = 1'b1;
        #Q scl = 1'b1;
        #Q sda_drv = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask
    // Nine clocks, msb first; data changes only while the clock is low
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_drv = tx[i];
            #Q scl = 1'b1;
            #Q rx[i] = sda;
            #Q scl = 1'b0;
            #Q;
        end
    endtask
    // Stop: data rises while the clock is high, then the clock stays still
    task automatic stop();
        sda_drv = 1'b0;
        #Q scl = 1'b1;
        #Q sda_drv = 1'b1;
        #Q;
    endtask
    // Single write; callers keep to the five defined addresses
    task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
        logic [8:0] r0, r1, r2;
        start();
        xfer({dev, 1'b0, 1'b1}, r0);
        xfer({a, 1'b1}, r1);
        xfer({d, 1'b1}, r2);
        stop();
        acks = {r0[0], r1[0], r2[0]};
    endtask
    // Single read through a repeated start; the last byte is not acknowledged
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        logic [8:0] r0, r1, r2, r3;
        start();
        xfer({`BCC_TARGET_ADDR, 1'b0, 1'b1}, r0);
        xfer({a, 1'b1}, r1);
        start();
        xfer({`BCC_TARGET_ADDR, 1'b1, 1'b1}, r2);
        xfer(9'h1ff, r3);
        stop();
        q = r3[8:1];
    endtask
endmodule // bcc_ctl_model

// ===== buck_converter_config_registers_test.sv
// Self-checking testbench of the converter register bank against a behavioural model
`timescale 1ns/1ps
`include "bcc_cfg.svh"
module buck_converter_config_registers_test;
    logic sys_clk, rst_n, mode_sync_pin, scl, sda, sda_out, sda_oe, init_start;
    logic [7:0] strap, output_setpoint_code, auxiliary_control;
    logic [1:0] strap_sc, setpoint_scale_select, setpoint_slew_select, softstart_duration;
    logic [5:0] event_in;
    logic [21:0] target_uv;
    logic [13:0] slew_uv_per_us;
    logic [12:0] softstart_us;
    logic spread_spectrum_on, switching_on, forced_fixed_freq_on, output_discharge_on;
    logic retry_mode_on;
    int failures = 0, cmp_count = 0, n_init = 0;
    int m_set, m_main, m_rng, m_aux, m_flags, s_code, s_scale;
    int slew_t[4] = '{10000, 5000, 1250, 500};
    int ss_t[4] = '{500, 1000, 2000, 4000};

    bcc_ctl_model ctl (.sda_oe(sda_oe), .scl(scl), .sda(sda));
    bcc_regbank DUT (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .setpoint_strap_pins(strap),
        .setpoint_strap_scale(strap_sc), .mode_sync_pin(mode_sync_pin), .event_in(event_in),
        .output_setpoint_code(output_setpoint_code), .setpoint_scale_select(setpoint_scale_select),
        .target_uv(target_uv), .spread_spectrum_on(spread_spectrum_on),
        .switching_on(switching_on), .forced_fixed_freq_on(forced_fixed_freq_on),
        .output_discharge_on(output_discharge_on), .retry_mode_on(retry_mode_on),
        .setpoint_slew_select(setpoint_slew_select), .slew_uv_per_us(slew_uv_per_us),
        .softstart_duration(softstart_duration), .softstart_us(softstart_us),
        .auxiliary_control(auxiliary_control), .init_start(init_start));

    // Clock and a count of initialization pulses
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (init_start === 1'b1) n_init++;
    // Hang guard: the whole run fits well inside this limit
    initial begin
        #1ms;
        failures++;
        end_sim();
    end

    task automatic end_sim();
        if (failures == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Model of the target voltage in microvolts
    function automatic int tgt(int c, int r);
        return (r == 3) ? 800000 + c * 10000 : 400000 + c * (1250 << r);
    endfunction
    // Defaults; setpoint and scale come from the straps seen at power-up only
    task automatic defaults();
        m_set = s_code;
        m_main = 'h2a;
        m_rng = s_scale * 4 + 1;
        m_aux = 0;
        m_flags = 2;
    endtask
    task automatic chk_ports();
        chk(output_setpoint_code, m_set);
        chk(setpoint_scale_select, m_rng >> 2);
        chk(target_uv, tgt(m_set, m_rng >> 2));
        chk({spread_spectrum_on, switching_on, forced_fixed_freq_on, output_discharge_on,
            retry_mode_on, setpoint_slew_select}, m_main);
        chk(slew_uv_per_us, slew_t[m_main & 3]);
        chk(softstart_duration, m_rng & 3);
        chk(softstart_us, ss_t[m_rng & 3]);
        chk(auxiliary_control, m_aux);
        chk(sda_out, 1'b0);
    endtask
    // Write through the serial port, then let the model follow
    task automatic wr(input int a, input int d);
        ctl.wr(`BCC_TARGET_ADDR, 8'(a), 8'(d));
        chk(ctl.acks, 3'h0);
        if (a == 0) m_set = d & 'hff;
        if (a == 1) m_main = d & 'h7f;
        if (a == 2) m_rng = d & 'h0f;
        if (a == 3) m_aux = d & 'hff;
        if (a == 1 && (d & 'h80) != 0) defaults();
        repeat (4) @(negedge sys_clk);
        chk_ports();
    endtask
    task automatic rd_chk(input int a);
        logic [7:0] q;
        int e;
        ctl.rd(8'(a), q);
        e = (a == 0) ? m_set : (a == 1) ? m_main : (a == 2) ? m_rng : (a == 3) ? m_aux : 0;
        if (a == 4) e = m_flags;
        chk(q, e);
        if (a == 4) m_flags = 0; // Reading the flags clears them
    endtask
    // All five registers plus two unmapped places, the top one at the pointer wrap
    task automatic chk_regs();
        for (int i = 0; i < 7; i++) rd_chk(i == 6 ? 255 : i);
        chk_ports();
    endtask

    // Main sequence; inputs other than the serial lines change on falling edges
    initial begin
        rst_n = 1'b0;
        mode_sync_pin = 1'b0;
        event_in = 6'h00;
        strap = 8'($urandom(42));
        strap_sc = 2'($urandom);
        s_code = strap;
        s_scale = strap_sc;
        defaults();
        repeat (6) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (20) @(negedge sys_clk);
        chk(n_init, 1);
        chk_regs();
        chk_regs();
        // Every slew, scale and soft-start code; retry bit random in a standalone setup
        for (int k = 0; k < 4; k++) begin
            wr(0, $urandom);
            wr(1, ($urandom & 'h7c) | k);
            wr(2, k * 5); // Upper nibble written as zero
            wr(3, $urandom);
        end
        wr(0, 'hff);
        wr(4, 'hff);
        chk_regs();
        // Wrong target address gets no acknowledge and changes nothing
        ctl.wr(7'h4b, 8'h00, 8'h00);
        chk(ctl.acks[2], 1'b1);
        chk_ports();
        // Forced mode follows the pin while the bit is clear
        wr(1, m_main & 'h6f);
        mode_sync_pin = 1'b1;
        repeat (10) @(negedge sys_clk);
        chk(forced_fixed_freq_on, 1'b1);
        mode_sync_pin = 1'b0;
        repeat (300) @(negedge sys_clk);
        chk(forced_fixed_freq_on, 1'b0);
        wr(1, m_main | 'h10);
        // Each event latches its flag until a read
        for (int i = 0; i < 6; i++) begin
            @(negedge sys_clk);
            event_in = 6'(1 << i);
            repeat (5) @(negedge sys_clk);
            event_in = 6'h00;
            m_flags = 1 << i;
            rd_chk(4);
            rd_chk(4);
        end
        // Soft reset after the straps moved: captured strap values return
        @(negedge sys_clk);
        strap = ~strap;
        strap_sc = ~strap_sc;
        wr(1, 'h80);
        chk(n_init, 2);
        chk_regs();
        end_sim();
    end
endmodule // buck_converter_config_registers_test
